// *** pkg/stm_regs.vh ***
// Constants for the standard timer block: mode codes, pin function codes and timing.
// Assumes the timer clock is the module clock, so one timer period equals one clk cycle.
`ifndef STM_REGS_VH
`define STM_REGS_VH

// Mode field codes (mode_select_hi, mode_select_lo).
`define STM_MODE_COMPARE 2'h0
`define STM_MODE_CAPTURE 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_COUNTER 2'h3

// Pin function codes in PWM and one-shot modes.
`define STM_PF_FORCE_INACTIVE 2'h0
`define STM_PF_FORCE_ACTIVE 2'h1
`define STM_PF_PWM 2'h2
`define STM_PF_ONE_SHOT 2'h3

// Pin function codes in capture mode.
`define STM_PF_CAP_RISE 2'h0
`define STM_PF_CAP_FALL 2'h1
`define STM_PF_CAP_BOTH 2'h2
`define STM_PF_CAP_OFF 2'h3

// Pin function codes in compare match mode.
`define STM_PF_CMP_NONE 2'h0
`define STM_PF_CMP_LOW 2'h1
`define STM_PF_CMP_HIGH 2'h2
`define STM_PF_CMP_TOGGLE 2'h3

// Widths and reset values.
`define STM_CNT_W 16
`define STM_COMPARE_P_VALUE_W 8
`define STM_CNT_RESET 16'h0000

// Timer clock period in ns and the capture flag delay in half timer periods.
`define STM_TCLK_NS 10
`define STM_CAP_FLAG_DELAY_HALF 1
// Least delay, rounded up to whole cycles; a delay of zero half periods gives zero cycles.
`define STM_CAP_FLAG_DELAY_CYC ((`STM_CAP_FLAG_DELAY_HALF + 1) / 2)

`endif

// *** core/stm_pin_sync.v ***
// Three-flop synchroniser with agreement filter and edge pulses for one pin.
// Assumes the pin is asynchronous to clk; edges are reported once flops two and three agree.
`timescale 1ns/10ps
`default_nettype none

module stm_pin_sync (
   input wire clk,
   input wire rstn,
   input wire pinIn,
   output reg levelQ,
   output reg riseQ,
   output reg fallQ
);

   reg sync1_q;
   reg sync2_q;
   reg sync3_q;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         levelQ <= 1'b0;
         riseQ <= 1'b0;
         fallQ <= 1'b0;
      end else begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // A single-cycle glitch that never reaches agreement is filtered out.
         if (sync2_q == sync3_q) begin
            levelQ <= sync3_q;
         end
         riseQ <= (sync2_q == sync3_q) && sync3_q && !levelQ;
         fallQ <= (sync2_q == sync3_q) && !sync3_q && levelQ;
      end
   end

endmodule // stm_pin_sync

`default_nettype wire

// *** core/stm_timer.v ***
// 16-bit standard timer core: PWM with duty/period swap, one-shot pulse and input capture.
// Assumes clk is the selected timer clock and that software drives the control ports.
//
// What this block does
// - Swap set: period compare A, duty P*256
// - Forced pin levels keep PWM running internally
// - PWM ignores clear select; period comparator clears
// - One-shot: counter-on rise starts pulse
// - One-shot: trigger pin edge sets counter-on
// - One-shot: A match clears counter-on, flags
// - One-shot: counter zeroed only on rise
// - Capture mode is mode 01, edge selectable
// - Capture: counter starts on counter-on rise
// - Capture edge copies counter into compare A
// - Capture: counter free runs until off
// - Capture: P match zeroes counter, flags
// - Pin function 11 disables capture only
// - Pulses under two clocks may be lost
// - A flag follows capture latch later
// - Capture edge to latch is bounded
// - Capture mode drives no output function
// - PWM: mode 10, pin 10, polarity bits
// - Swap clear: period P*256, duty compare A
// - Counter-on rise restores initial pin level in compare and one-shot modes
`timescale 1ns/10ps
`default_nettype none
`include "stm_regs.vh"

module stm_timer #(
   parameter CNT_W = `STM_CNT_W,
   parameter COMPARE_P_VALUE_W = `STM_COMPARE_P_VALUE_W
) (
   input wire clk,
   input wire rstn,
   input wire modeSelectHi,
   input wire modeSelectLo,
   input wire pinFunctionHi,
   input wire pinFunctionLo,
   input wire outputInitialState,
   input wire outputPolarity,
   input wire counterClearSelect,
   input wire dutyPeriodSwap,
   input wire counterOnWrite,
   input wire counterOnData,
   input wire compareAWrite,
   input wire [CNT_W-1:0] compareAData,
   input wire [COMPARE_P_VALUE_W-1:0] compareP,
   input wire compareAFlagClr,
   input wire comparePFlagClr,
   input wire extClockTriggerPin,
   input wire captureInputPin,
   output reg counterOn_q,
   output reg [CNT_W-1:0] counter_q,
   output reg [CNT_W-1:0] compareAValue_q,
   output reg compareAFlag_q,
   output reg comparePFlag_q,
   output reg timerOut_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode and pin synchronisers.

   wire [1:0] mode;
   wire [1:0] pinFunction;
   wire modeCompare;
   wire modeCapture;
   wire modePwmFamily;
   wire modeOneShot;
   wire modePwm;
   wire trigRise;
   wire capRise;
   wire capFall;

   assign mode = {modeSelectHi, modeSelectLo};
   assign pinFunction = {pinFunctionHi, pinFunctionLo};
   assign modeCompare = (mode == `STM_MODE_COMPARE);
   assign modeCapture = (mode == `STM_MODE_CAPTURE);
   assign modePwmFamily = (mode == `STM_MODE_PWM);
   assign modeOneShot = modePwmFamily && (pinFunction == `STM_PF_ONE_SHOT);
   assign modePwm = modePwmFamily && !modeOneShot;

   // Only the trigger's rising edge starts a pulse, so its level and falling edge are left open.
   stm_pin_sync u_trig_sync (
      .clk(clk),
      .rstn(rstn),
      .pinIn(extClockTriggerPin),
      .levelQ(),
      .riseQ(trigRise),
      .fallQ()
   );

   // The filter needs two agreeing samples, so pulses under two clocks may vanish.
   stm_pin_sync u_cap_sync (
      .clk(clk),
      .rstn(rstn),
      .pinIn(captureInputPin),
      .levelQ(),
      .riseQ(capRise),
      .fallQ(capFall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Comparators.

   reg onPrev_q;
   wire onRise;
   wire [CNT_W-1:0] cntPlusOne;
   wire [CNT_W-1:0] pPeriodEnd;
   wire aMatch;
   wire aPeriodEnd;
   wire pMatch;
   wire [CNT_W:0] pDuty;
   wire dutyActive;

   assign onRise = counterOn_q && !onPrev_q;
   assign cntPlusOne = counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
   assign pPeriodEnd = {compareP, {(CNT_W-COMPARE_P_VALUE_W){1'b0}}};
   // A zero compare P wraps the sum, so the period becomes the full 65536 counts.
   assign pMatch = counterOn_q && !onRise && (cntPlusOne == pPeriodEnd);
   // No match in the restart cycle, where the counter still shows its stale residual value.
   assign aMatch = counterOn_q && !onRise && (counter_q == compareAValue_q);
   assign aPeriodEnd = counterOn_q && (cntPlusOne == compareAValue_q);
   // Duty from compare P, with zero standing for 65536 clocks.
   assign pDuty = (compareP == {COMPARE_P_VALUE_W{1'b0}}) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, pPeriodEnd};
   assign dutyActive = dutyPeriodSwap ? ({1'b0, counter_q} < pDuty)
                                      : (counter_q < compareAValue_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Capture edge selection.

   reg capEdge;

   always @* begin
      capEdge = 1'b0;
      case (pinFunction)
         `STM_PF_CAP_RISE: begin
            capEdge = capRise;
         end
         `STM_PF_CAP_FALL: begin
            capEdge = capFall;
         end
         `STM_PF_CAP_BOTH: begin
            capEdge = capRise || capFall;
         end
         default: begin
            capEdge = 1'b0;
         end
      endcase
   end

   wire capTake;
   assign capTake = modeCapture && counterOn_q && capEdge;

   ////////////////////////////////////////////////////////////////////////////////
   // Counter-on bit and counter.

   reg counterOn_d;
   reg [CNT_W-1:0] counter_d;
   reg counterClear;

   always @* begin
      counterOn_d = counterOn_q;
      if (counterOnWrite) begin
         counterOn_d = counterOnData;
      end
      if (modeOneShot && trigRise) begin
         counterOn_d = 1'b1;
      end
      // The compare A match ends the pulse even if a trigger lands in the same cycle.
      if (modeOneShot && aMatch) begin
         counterOn_d = 1'b0;
      end
   end

   always @* begin
      counterClear = 1'b0;
      if (modePwm) begin
         counterClear = dutyPeriodSwap ? aPeriodEnd : pMatch;
      end else if (modeCapture) begin
         counterClear = pMatch;
      end else if (modeCompare || (mode == `STM_MODE_COUNTER)) begin
         // Compare and timer modes keep a plain clear here; their finer behaviour is not modelled.
         counterClear = counterClearSelect ? (aMatch && (compareAValue_q != {CNT_W{1'b0}})) : pMatch;
      end
   end

   always @* begin
      counter_d = counter_q;
      if (onRise) begin
         counter_d = `STM_CNT_RESET;
      end else if (counterOn_q) begin
         // Capture mode keeps counting whatever the capture pin does.
         counter_d = counterClear ? `STM_CNT_RESET : cntPlusOne;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         counterOn_q <= 1'b0;
         onPrev_q <= 1'b0;
         counter_q <= `STM_CNT_RESET;
      end else begin
         counterOn_q <= counterOn_d;
         onPrev_q <= counterOn_q;
         counter_q <= counter_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare A register and the delayed capture flag.

   reg [`STM_CAP_FLAG_DELAY_CYC-1:0] capFlagPend_q;
   wire [`STM_CAP_FLAG_DELAY_CYC:0] capFlagShift;
   wire capFlagSet;

   // The flag trails the latch so that the captured value is already in place when it rises.
   assign capFlagShift = {capFlagPend_q, capTake};

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         compareAValue_q <= {CNT_W{1'b0}};
         capFlagPend_q <= {`STM_CAP_FLAG_DELAY_CYC{1'b0}};
      end else begin
         // A capture beats a software write landing in the same cycle.
         if (capTake) begin
            compareAValue_q <= counter_q;
         end else if (compareAWrite) begin
            compareAValue_q <= compareAData;
         end
         capFlagPend_q <= capFlagShift[`STM_CAP_FLAG_DELAY_CYC-1:0];
      end
   end

   assign capFlagSet = capFlagPend_q[`STM_CAP_FLAG_DELAY_CYC-1];

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt flags; a set in the same cycle as a clear wins.

   reg aFlagSet;
   reg pFlagSet;

   always @* begin
      aFlagSet = 1'b0;
      pFlagSet = 1'b0;
      if (modePwm) begin
         aFlagSet = aMatch;
         pFlagSet = pMatch;
      end else if (modeOneShot) begin
         aFlagSet = aMatch;
      end else if (modeCapture) begin
         aFlagSet = capFlagSet;
         pFlagSet = pMatch;
      end else begin
         aFlagSet = aMatch && (compareAValue_q != {CNT_W{1'b0}});
         pFlagSet = pMatch && !counterClearSelect;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         compareAFlag_q <= 1'b0;
         comparePFlag_q <= 1'b0;
      end else begin
         compareAFlag_q <= aFlagSet || (compareAFlag_q && !compareAFlagClr);
         comparePFlag_q <= pFlagSet || (comparePFlag_q && !comparePFlagClr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output pin.
   // The level is held before polarity inversion; polarity is applied at the pin flop.

   reg outLevel_q;
   reg outLevel_d;
   reg timerOut_d;

   always @* begin
      outLevel_d = outLevel_q;
      if (onRise) begin
         outLevel_d = outputInitialState;
      end
      if (modePwm) begin
         // Internal generation keeps running whatever the pin function forces.
         outLevel_d = dutyActive ? outputInitialState : !outputInitialState;
      end else if (modeOneShot) begin
         outLevel_d = counterOn_q ? outputInitialState : !outputInitialState;
      end else if (modeCompare && counterOn_q && !onRise && aFlagSet) begin
         case (pinFunction)
            `STM_PF_CMP_LOW: begin
               outLevel_d = 1'b0;
            end
            `STM_PF_CMP_HIGH: begin
               outLevel_d = 1'b1;
            end
            `STM_PF_CMP_TOGGLE: begin
               outLevel_d = !outLevel_q;
            end
            default: begin
               outLevel_d = outLevel_q;
            end
         endcase
      end
   end

   always @* begin
      timerOut_d = 1'b0;
      if (modePwm) begin
         case (pinFunction)
            `STM_PF_FORCE_INACTIVE: begin
               timerOut_d = !outputInitialState ^ outputPolarity;
            end
            `STM_PF_FORCE_ACTIVE: begin
               timerOut_d = outputInitialState ^ outputPolarity;
            end
            default: begin
               timerOut_d = outLevel_d ^ outputPolarity;
            end
         endcase
      end else if (modeOneShot || modeCompare) begin
         timerOut_d = outLevel_d ^ outputPolarity;
      end else begin
         // Capture and timer/counter modes drive no output function.
         timerOut_d = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outLevel_q <= 1'b0;
         timerOut_q <= 1'b0;
      end else begin
         outLevel_q <= outLevel_d;
         timerOut_q <= timerOut_d;
      end
   end

endmodule // stm_timer

`default_nettype wire

// *** bench/stm_timer_checker.sv ***
// Concurrent checks on the standard timer core, bound to every stm_timer.
// Assumes one clock domain and the mode and pin function codes of stm_regs.vh.
`timescale 1ns/10ps
`default_nettype none
`include "stm_regs.vh"

module stm_timer_checker #(
   parameter CNT_W = 16,
   parameter COMPARE_P_VALUE_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic modeSelectHi,
   input wire logic modeSelectLo,
   input wire logic pinFunctionHi,
   input wire logic pinFunctionLo,
   input wire logic outputInitialState,
   input wire logic outputPolarity,
   input wire logic dutyPeriodSwap,
   input wire logic compareAWrite,
   input wire logic [COMPARE_P_VALUE_W-1:0] compareP,
   input wire logic counterOn_q,
   input wire logic [CNT_W-1:0] counter_q,
   input wire logic [CNT_W-1:0] compareAValue_q,
   input wire logic compareAFlag_q,
   input wire logic comparePFlag_q,
   input wire logic timerOut_q
);
   ////////////////////////////////////////////////////////////
   wire [1:0] mode = {modeSelectHi, modeSelectLo};
   wire [1:0] pf = {pinFunctionHi, pinFunctionLo};
   wire pwm = (mode == `STM_MODE_PWM) && (pf != `STM_PF_ONE_SHOT);
   wire shot = (mode == `STM_MODE_PWM) && (pf == `STM_PF_ONE_SHOT);
   wire cap = (mode == `STM_MODE_CAPTURE);
   wire duty = pwm && (pf == `STM_PF_PWM) && !dutyPeriodSwap && counterOn_q;
   wire [CNT_W-1:0] pTop = {compareP, 8'h00};
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // The counter still holds its old value in the cycle where counter-on rises, so matches need two on cycles.
   chk_ctr_restart: assert property ($rose(counterOn_q) |=> counter_q == 0)
      else $error("counter not zeroed on start");
   chk_ctr_hold: assert property (!counterOn_q ##1 !counterOn_q |-> $stable(counter_q))
      else $error("counter moved while off");
   chk_p_wrap: assert property (((pwm && !dutyPeriodSwap) || cap) && counterOn_q && $past(counterOn_q)
      && counter_q + 1'b1 == pTop |=> counter_q == 0 && comparePFlag_q) else $error("P match missed");
   chk_swap_period: assert property (pwm && dutyPeriodSwap && counterOn_q && $past(counterOn_q)
      && counter_q + 1'b1 == compareAValue_q |=> counter_q == 0) else $error("swap period wrong");
   chk_pwm_duty: assert property ($past(duty) && $past(counterOn_q, 2) && duty |-> timerOut_q ==
      ((($past(counter_q) < $past(compareAValue_q)) ~^ $past(outputInitialState)) ^ $past(outputPolarity)))
      else $error("pwm level wrong");
   chk_force_pin: assert property (pwm && !pf[1] && $past(pwm && !pf[1]) && $stable(counterOn_q)
      && $past(counterOn_q) == $past(counterOn_q, 2)
      |-> timerOut_q == $past(pinFunctionLo ~^ outputInitialState ^ outputPolarity)) else $error("forced pin wrong");
   chk_shot_end: assert property (shot && counterOn_q && $past(counterOn_q) && counter_q == compareAValue_q
      |=> !counterOn_q && compareAFlag_q) else $error("pulse not ended on A match");
   chk_cap_flag: assert property (cap && $past(cap) && !$past(compareAWrite) && !$stable(compareAValue_q)
      |=> compareAFlag_q) else $error("capture flag missing");
   chk_cap_silent: assert property (cap && pf == `STM_PF_CAP_OFF
      && $past(cap && pf == `STM_PF_CAP_OFF && !compareAWrite) |-> $stable(compareAValue_q))
      else $error("capture while disabled");
   chk_cap_no_out: assert property (cap && $past(cap) |-> !timerOut_q)
      else $error("output driven in capture");
   cover property (shot && $fell(counterOn_q));
   cover property (cap && $rose(compareAFlag_q));
   cover property (pwm && dutyPeriodSwap && $fell(counter_q[0]) && counter_q == 0);
endmodule // stm_timer_checker

bind stm_timer stm_timer_checker #(.CNT_W(CNT_W), .COMPARE_P_VALUE_W(COMPARE_P_VALUE_W)) chk (.clk, .rstn, .modeSelectHi,
   .modeSelectLo, .pinFunctionHi, .pinFunctionLo, .outputInitialState, .outputPolarity, .dutyPeriodSwap,
   .compareAWrite, .compareP, .counterOn_q, .counter_q, .compareAValue_q, .compareAFlag_q, .comparePFlag_q,
   .timerOut_q);
`default_nettype wire

// *** bench/stm_pin_model.sv ***
// Far-side model of the timer pins: external trigger and capture input.
// Assumes calls arrive just after a rising clk edge, as the bench drives.
`timescale 1ns/10ps
`default_nettype none

module stm_pin_model (
   input wire logic clk,
   output var logic trigPin,
   output var logic capPin
);
   ////////////////////////////////////////////////////////////
   initial trigPin = 1'b0;
   initial capPin = 1'b0;
   // Every level is held two clocks, since anything shorter may slip past the synchroniser.
   task automatic setTrig(input logic v);
      trigPin = v;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic setCap(input logic v);
      capPin = v;
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule // stm_pin_model
`default_nettype wire

// *** bench/stm_timer_bench.sv ***
// Self-checking bench for stm_timer: PWM, one-shot and capture sequences.
// Assumes stm_pin_model drives the trigger and capture pins.
`timescale 1ns/10ps
`default_nettype none
`include "stm_regs.vh"

module stm_timer_bench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [1:0] pf = 2'h0;
   logic oc = 1'b0, pol = 1'b0, ccs = 1'b0, swap = 1'b0, onWr = 1'b0, onData = 1'b0;
   logic aWr = 1'b0, aClr = 1'b0, pClr = 1'b0, hit;
   logic [15:0] aData = 16'h0000, t0, prevA;
   logic [7:0] compP = 8'h00, d;
   logic trigPin, capPin, counterOn_q, compareAFlag_q, comparePFlag_q, timerOut_q;
   logic [15:0] counter_q, compareAValue_q;
   int failures = 0, checksDone = 0, hi;
   // The timer clock never stops, so capture always has its counter clock.
   always #5 clk = ~clk;
   stm_timer uut (.clk, .rstn, .modeSelectHi(mode[1]), .modeSelectLo(mode[0]), .pinFunctionHi(pf[1]),
      .pinFunctionLo(pf[0]), .outputInitialState(oc), .outputPolarity(pol), .counterClearSelect(ccs),
      .dutyPeriodSwap(swap), .counterOnWrite(onWr), .counterOnData(onData), .compareAWrite(aWr),
      .compareAData(aData), .compareP(compP), .compareAFlagClr(aClr), .comparePFlagClr(pClr),
      .extClockTriggerPin(trigPin), .captureInputPin(capPin), .counterOn_q, .counter_q, .compareAValue_q,
      .compareAFlag_q, .comparePFlag_q, .timerOut_q);
   stm_pin_model pins (.clk, .trigPin, .capPin);
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic setOn(input logic v);
      onWr = 1'b1;
      onData = v;
      step(1);
      onWr = 1'b0;
   endtask
   task automatic writeA(input logic [15:0] v);
      aWr = 1'b1;
      aData = v;
      step(1);
      aWr = 1'b0;
   endtask
   task automatic clrFlags;
      aClr = 1'b1;
      pClr = 1'b1;
      step(1);
      aClr = 1'b0;
      pClr = 1'b0;
   endtask
   task automatic measure(input int n);
      hi = 0;
      repeat (n) begin
         step(1);
         hi += (timerOut_q === 1'b1);
      end
   endtask
   task automatic waitOn(input logic v);
      int k;
      k = 0;
      while (counterOn_q !== v && k < 20) begin
         step(1);
         k++;
      end
      if (counterOn_q !== v) begin
         check("counter-on wait", counterOn_q, v);
         conclude();
      end
   endtask
   initial begin
      step(4);
      rstn = 1'b1;
      step(1);
      mode = `STM_MODE_PWM;
      pf = `STM_PF_PWM;
      oc = 1'b1;
      ccs = 1'b1;
      compP = 8'h01;
      writeA(16'h0040);
      clrFlags();
      setOn(1'b1);
      step(300);
      for (int p = 0; p < 2; p++) begin
         pol = p[0];
         step(2);
         measure(256);
         check("pwm duty", hi, p ? 192 : 64);
      end
      check("pwm flags", {compareAFlag_q, comparePFlag_q}, 2'h3);
      pol = 1'b0;
      for (int f = 0; f < 2; f++) begin
         pf = f[1:0];
         step(2);
         t0 = counter_q;
         measure(100);
         check("forced pin", hi, f ? 100 : 0);
         check("counter runs", counter_q !== t0, 1);
      end
      $display("pwm test done");
      pf = `STM_PF_PWM;
      setOn(1'b0);
      swap = 1'b1;
      compP = 8'h00;
      writeA(16'h0064);
      setOn(1'b1);
      step(200);
      measure(100);
      check("swap duty", hi, 100);
      t0 = 16'h0000;
      repeat (200) begin
         step(1);
         if (counter_q > t0) t0 = counter_q;
      end
      check("swap period", t0, 99);
      $display("swap test done");
      setOn(1'b0);
      swap = 1'b0;
      pf = `STM_PF_ONE_SHOT;
      writeA(16'h0078);
      for (int s = 0; s < 2; s++) begin
         clrFlags();
         if (s == 0) pins.setTrig(1'b1);
         else setOn(1'b1);
         waitOn(1'b1);
         hi = 0;
         while (counterOn_q === 1'b1 && hi < 300) begin
            hi++;
            if (hi == 5) check("pulse level", timerOut_q, 1);
            step(1);
         end
         check("pulse width", hi, 122);
         if (hi >= 300) conclude();
         check("pulse flag", compareAFlag_q, 1);
         step(1);
         check("pulse idle", timerOut_q, 0);
         pins.setTrig(1'b0);
      end
      setOn(1'b1);
      step(5);
      setOn(1'b0);
      step(2);
      check("soft end", {counterOn_q, timerOut_q}, 2'h0);
      $display("one-shot test done");
      mode = `STM_MODE_CAPTURE;
      pol = 1'b1;
      compP = 8'h01;
      setOn(1'b1);
      for (int e = 0; e < 4; e++) begin
         pf = e[1:0];
         for (int lv = 1; lv >= 0; lv--) begin
            clrFlags();
            t0 = counter_q;
            prevA = compareAValue_q;
            pins.setCap(lv[0]);
            step(6);
            hit = (e == 2) || (e == 1 - lv);
            check("capture flag", compareAFlag_q, hit);
            d = compareAValue_q[7:0] - t0[7:0];
            if (hit) check("capture value", d >= 8'h03 && d <= 8'h07, 1);
            else check("no capture", compareAValue_q, prevA);
         end
      end
      t0 = counter_q;
      step(300);
      check("capture wrap", {comparePFlag_q, counter_q[15:8], counter_q !== t0}, 10'h201);
      check("capture output", timerOut_q, 0);
      $display("capture test done");
      conclude();
   end
endmodule // stm_timer_bench
`default_nettype wire
